// ---- hw/ring_filter_params.svh ----
// register offsets, field positions and widths for the ring length and filter bank
`ifndef RING_FILTER_PARAMS_SVH
`define RING_FILTER_PARAMS_SVH

`define RF_ADDR_W         8
`define RF_DATA_W         32
`define RF_OFS_RING_LEN   8'h06
`define RF_OFS_FILT0      8'h08
`define RF_OFS_FILT1      8'h09
`define RF_OFS_FILT2      8'h0A
`define RF_OFS_FILT3      8'h0B
`define RF_OFS_STATUS     8'h0C
`define RF_TX_LEN_HI      15
`define RF_TX_LEN_LO      12
`define RF_RX_LEN_HI      11
`define RF_RX_LEN_LO      8
`define RF_SLICE_W        16
`define RF_SLICES         4
`define RF_FILTER_W       64
`define RF_LEN_CODE_W     4
`define RF_ST_HALT_BIT    0
`define RF_ST_INIT_BIT    1
`define RF_ST_VALID_LO    2

`endif

// ---- hw/ring_filter_pkg.sv ----
// types shared by the ring length and filter bank
package ring_filter_pkg;
	typedef logic [3:0]  len_code_t;
	typedef logic [15:0] slice_t;
	typedef logic [63:0] filter_t;
	typedef enum logic [1:0] {
		ST_RUN    = 2'b00,
		ST_HALTED = 2'b01,
		ST_INIT   = 2'b11
	} ctrl_state_t;
endpackage : ring_filter_pkg

// ---- hw/slice_if.sv ----
// interface carrying one filter slice between the bank and a slice holder
`timescale 1ns/1ns
interface slice_if;
	import ring_filter_pkg::*;
	logic   sw_load;
	logic   init_load;
	slice_t sw_data;
	slice_t init_data;
	slice_t value;
	logic   valid;
	modport holder (input sw_load, input init_load, input sw_data, input init_data,
		output value, output valid);
	modport bank (output sw_load, output init_load, output sw_data, output init_data,
		input value, input valid);
endinterface : slice_if

// ---- hw/filter_slice.sv ----
// one 16-bit filter slice with its validity flag
`timescale 1ns/1ns
module filter_slice
	import ring_filter_pkg::*;
(
	input  wire logic CLK,
	input  wire logic RST,
	slice_if.holder   sl
);
	slice_t value;
	logic   valid;

	// contents never reset so they survive every reset; only validity restarts
	always_ff @(posedge CLK) begin
		if (sl.init_load) begin
			value <= sl.init_data;
		end else if (sl.sw_load) begin
			value <= sl.sw_data;
		end
	end

	// validity flag is bookkeeping, cleared at reset for software visibility
	always_ff @(posedge CLK) begin
		if (RST) begin
			valid <= 1'b0;
		end else if (sl.init_load || sl.sw_load) begin
			valid <= 1'b1;
		end
	end

	assign sl.value = value;
	assign sl.valid = valid;
endmodule : filter_slice

// ---- hw/ring_filter_regs.sv ----
// ring length shadow and multicast hash filter register bank
// How it works
// - init copies transmit ring code to 15-12
// - init copies receive ring code to 11-8
// - ring codes read only when halted; writes ignored
// - ring codes survive every reset and halt
// - ring register bits 7-0 read zero
// - bits 31-16 reserved, read back zero here
// - four 16-bit slices form 64-bit filter
// - slice valid after init load or write
// - filter read/write allowed only when halted
// - filter kept across resets and halt
`timescale 1ns/1ns
`include "ring_filter_params.svh"
module ring_filter_regs
	import ring_filter_pkg::*;
(
	input  wire logic                   CLK,
	input  wire logic                   RST,
	input  wire logic [`RF_ADDR_W-1:0]  ADDR,
	input  wire logic [`RF_DATA_W-1:0]  WDATA,
	input  wire logic                   WR,
	input  wire logic                   RD,
	output logic      [`RF_DATA_W-1:0]  RDATA,
	input  wire logic                   HALT,
	input  wire logic                   INIT_LOAD,
	input  wire logic [3:0]             INIT_TX_LEN,
	input  wire logic [3:0]             INIT_RX_LEN,
	input  wire logic [63:0]            INIT_FILTER,
	output logic      [63:0]            FILTER,
	output logic      [3:0]             TX_LEN,
	output logic      [3:0]             RX_LEN,
	output logic                        INIT_DONE
);
	len_code_t   tx_ring_len_code;
	len_code_t   rx_ring_len_code;
	logic        init_done;
	ctrl_state_t state;
	ctrl_state_t next_state;
	filter_t     multicast_hash_filter;
	logic [3:0]  slice_valid;
	logic [31:0] next_rdata;

	// address decode
	wire hit_ring   = (ADDR == `RF_OFS_RING_LEN);
	wire hit_status = (ADDR == `RF_OFS_STATUS);
	wire hit_filt   = (ADDR >= `RF_OFS_FILT0) && (ADDR <= `RF_OFS_FILT3);
	wire [1:0] filt_idx = ADDR[1:0];
	// writes only land while halted; init load is hardware and is never gated
	wire wr_ok = WR && HALT;
	wire rd_ok = RD && HALT;

	// one holder per slice, slice k carries filter bits 16k+15 .. 16k
	slice_if sl [`RF_SLICES] ();
	genvar k;
	generate
		for (k = 0; k < `RF_SLICES; k++) begin : g_slice
			assign sl[k].sw_load   = wr_ok && hit_filt && (filt_idx == 2'(k));
			assign sl[k].init_load = INIT_LOAD;
			assign sl[k].sw_data   = WDATA[`RF_SLICE_W-1:0];
			assign sl[k].init_data = INIT_FILTER[k*16 +: 16];
			assign multicast_hash_filter[k*16 +: 16] = sl[k].value;
			assign slice_valid[k] = sl[k].valid;
			filter_slice u_slice (
				.CLK (CLK),
				.RST (RST),
				.sl  (sl[k])
			);
		end
	endgenerate

	// ring codes have no reset term so resets and halt leave them intact
	always_ff @(posedge CLK) begin
		if (INIT_LOAD) begin
			tx_ring_len_code <= INIT_TX_LEN;
			rx_ring_len_code <= INIT_RX_LEN;
		end
	end

	// init completion marker, tells software the codes are meaningful
	always_ff @(posedge CLK) begin
		if (RST) begin
			init_done <= 1'b0;
		end else if (INIT_LOAD) begin
			init_done <= 1'b1;
		end
	end

	// small control view of the bank: running, halted, or taking an init load
	always_comb begin
		next_state = state;
		unique case (state)
			ST_RUN:    next_state = INIT_LOAD ? ST_INIT : (HALT ? ST_HALTED : ST_RUN);
			ST_HALTED: next_state = INIT_LOAD ? ST_INIT : (HALT ? ST_HALTED : ST_RUN);
			ST_INIT:   next_state = HALT ? ST_HALTED : ST_RUN;
			default:   next_state = ST_RUN;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			state <= ST_RUN;
		end else begin
			state <= next_state;
		end
	end

	// read mux; reserved upper half returns zero, a legal choice for undefined bits
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (rd_ok && hit_ring) begin
			next_rdata[`RF_TX_LEN_HI:`RF_TX_LEN_LO] = tx_ring_len_code;
			next_rdata[`RF_RX_LEN_HI:`RF_RX_LEN_LO] = rx_ring_len_code;
			// low byte stays zero
		end else if (rd_ok && hit_filt) begin
			next_rdata[15:0] = multicast_hash_filter[{filt_idx, 4'h0} +: 16];
		end else if (RD && hit_status) begin
			next_rdata[`RF_ST_HALT_BIT] = HALT;
			next_rdata[`RF_ST_INIT_BIT] = init_done;
			next_rdata[`RF_ST_VALID_LO +: 4] = slice_valid;
		end
		// bits 31-16 always zero
	end

	// read data stands one cycle after the strobe and only then
	always_ff @(posedge CLK) begin
		if (RST) begin
			RDATA <= 32'h0000_0000;
		end else begin
			RDATA <= next_rdata;
		end
	end

	// registered copies for the filter matcher and ring engines
	always_ff @(posedge CLK) begin
		if (RST) begin
			FILTER    <= 64'h0000_0000_0000_0000;
			TX_LEN    <= 4'h0;
			RX_LEN    <= 4'h0;
			INIT_DONE <= 1'b0;
		end else begin
			FILTER    <= multicast_hash_filter;
			TX_LEN    <= tx_ring_len_code;
			RX_LEN    <= rx_ring_len_code;
			INIT_DONE <= init_done;
		end
	end
endmodule : ring_filter_regs

// ---- testbench/ring_filter_checker.sv ----
// checker for the ring length and filter bank
`timescale 1ns/1ns
module ring_filter_checker (
	input wire logic        CLK,
	input wire logic        RST,
	input wire logic [7:0]  ADDR,
	input wire logic [31:0] WDATA,
	input wire logic        WR,
	input wire logic        RD,
	input wire logic [31:0] RDATA,
	input wire logic        HALT,
	input wire logic        INIT_LOAD,
	input wire logic [63:0] INIT_FILTER,
	input wire logic [63:0] FILTER,
	input wire logic [3:0]  TX_LEN,
	input wire logic [3:0]  RX_LEN
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	// ring register or one of the four slices
	wire prot = ADDR == 8'h06 || ADDR[7:2] == 6'h02;
	// read side: zero fields and running refusal
	a_run_rd_zero: assert property (RD && !HALT && prot |=> RDATA == 32'h0)
		else $error("read while running not zero");
	a_ring_low_zero: assert property (RD && ADDR == 8'h06 |=> RDATA[7:0] == 8'h00)
		else $error("ring low byte not zero");
	a_resv_zero: assert property (RD |=> RDATA[31:16] == 16'h0000)
		else $error("reserved half not zero");
	a_ring_codes: assert property (RD && HALT && ADDR == 8'h06
		|=> RDATA[15:8] == {TX_LEN, RX_LEN})
		else $error("ring codes read wrong");
	// load paths: copies show two edges later
	a_init_filt: assert property (INIT_LOAD |-> ##2 FILTER == $past(INIT_FILTER, 2))
		else $error("filter not loaded by init");
	a_slice_wr: assert property (WR && HALT && !INIT_LOAD && ADDR[7:2] == 6'h02 |-> ##2
		16'(FILTER >> 16 * ($past(ADDR, 2) - 8'h08)) == 16'($past(WDATA, 2)))
		else $error("halted slice write lost");
	// refused writes leave contents alone
	a_wr_ignored: assert property (WR && !HALT && !INIT_LOAD |=> ##1 $stable(FILTER))
		else $error("running write changed filter");
	a_ring_wr_ign: assert property (WR && ADDR == 8'h06 && !INIT_LOAD
		|=> ##1 $stable({TX_LEN, RX_LEN}))
		else $error("ring write took effect");
endmodule : ring_filter_checker

bind ring_filter_regs ring_filter_checker i_chk (.*);

// ---- testbench/ring_filter_regs_test.sv ----
// self-checking bench for the ring length and filter bank
`timescale 1ns/1ns
module ring_filter_regs_test;
	import ring_filter_pkg::*;
	logic        CLK = 0, RST = 1, WR = 0, RD = 0, HALT = 1, INIT_LOAD = 0, INIT_DONE;
	logic [7:0]  ADDR = 8'h00, rl;
	logic [31:0] WDATA = 32'h0, RDATA, d;
	logic [3:0]  INIT_TX_LEN = 4'h0, INIT_RX_LEN = 4'h0, TX_LEN, RX_LEN;
	logic [63:0] INIT_FILTER = 64'h0, FILTER;
	filter_t     f;
	int          n_mismatch = 0, tests_run = 0, cyc = 0;
	ring_filter_regs i_dut (.*);
	// 10 MHz clock
	always #50 CLK = ~CLK;
	// a hang is cut short well past the expected hundred or so cycles
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			conclude();
		end
	end
	task chk(string n, logic [63:0] s, logic [63:0] e);
		tests_run++;
		if (s !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task wr(logic [7:0] a, logic [31:0] v);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= v;
		WR <= 1;
		@(posedge CLK);
		WR <= 0;
	endtask : wr
	// data stand only in the cycle after the strobe
	task rd(logic [7:0] a);
		@(posedge CLK);
		ADDR <= a;
		RD <= 1;
		@(posedge CLK);
		RD <= 0;
		#1 d = RDATA;
	endtask : rd
	// halted view of the bank; zero while running
	function logic [31:0] exp_rd(logic [7:0] a);
		if (!HALT) return 32'h0;
		if (a == 8'h06) return {16'h0, rl, 8'h00};
		return {16'h0, 16'(f >> 16 * (a - 8'h08))};
	endfunction : exp_rd
	task chk_all(string n);
		for (int a = 6; a < 12; a++) begin
			if (a != 7) begin
				rd(8'(a));
				chk(n, d, exp_rd(8'(a)));
			end
		end
		rd(8'h0F);
		chk("unmapped", d, 0);
		$display("test %s done", n);
	endtask : chk_all
	task conclude();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : conclude
	initial begin
		void'($urandom(32'hCC360177));
		repeat (20) @(posedge CLK);
		RST <= 0;
		// init load with random codes and filter
		@(posedge CLK);
		{INIT_TX_LEN, INIT_RX_LEN} <= 8'($urandom);
		INIT_FILTER <= {$urandom, $urandom};
		INIT_LOAD <= 1;
		@(posedge CLK);
		INIT_LOAD <= 0;
		rl = {INIT_TX_LEN, INIT_RX_LEN};
		f = INIT_FILTER;
		chk_all("init");
		chk("codes", {TX_LEN, RX_LEN}, rl);
		chk("init flag", INIT_DONE, 1);
		rd(8'h0C);
		chk("status after init", d, 32'h0000_003F);
		// halted writes keep reserved half zero; ring write must be ignored
		for (int i = 0; i < 8; i++) begin
			d = {16'h0000, 16'($urandom)};
			wr(8'h08 + 8'(i % 4), d);
			f[16 * (i % 4) +: 16] = d[15:0];
		end
		wr(8'h06, {16'h0000, 8'($urandom), 8'h00});
		chk_all("write");
		// running: writes ignored, reads zero
		HALT <= 0;
		wr(8'h09, {16'h0000, 16'($urandom)});
		chk_all("run");
		// reset in mid-run keeps contents
		RST <= 1;
		@(posedge CLK);
		RST <= 0;
		HALT <= 1;
		chk_all("reset");
		chk("filter", FILTER, f);
		chk("codes after reset", {TX_LEN, RX_LEN}, rl);
		chk("init flag reset", INIT_DONE, 0);
		rd(8'h0C);
		chk("status after reset", d, 32'h0000_0001);
		conclude();
	end
endmodule : ring_filter_regs_test
